// ---- logic/thh_handshake.sv ----
// Handler port handshake, result and alarm logic of the impedance meter.
// Notes on behaviour
// - Assert contact-fail output when DC resistance is outside contact-check limits.
// - While panel-lock is asserted, ignore every front-panel key.
// - Assert alarm on self-test fault, power interruption or circuit malfunction.
// - A power-interruption alarm lasts only as long as power loss.
// - Assert analog-done when acquisition ends; handler may change parts.
// - Assert cycle-done at cycle end; data and comparator outputs then valid.
// - Begin measurement no later than 600 us after trigger edge.
// - Triggers arriving during the post-cycle wait are ignored.
// - Post-cycle wait grows with points, beeper, limit test, bin sorting.
// - Beeper adds about 100 ms to the post-cycle wait.
// - Comparison and output driving take about half a millisecond.
// - Display update takes about 3 ms plus 6 ms per point.
// - Trigger edge, rising or falling, is chosen by a setting.
// - Names with a leading slash are active low on both sides.
// - Overall fail on contact fail, no bin match, or limit failure.
module thh_handshake (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_ext_trigger_n,
	input wire logic i_key_lock_n,
	input wire thh_pkg::thh_cfg_t i_cfg,
	input wire logic i_analog_end,
	input wire thh_pkg::thh_result_t i_result,
	input wire logic i_selftest_fault,
	input wire logic i_power_loss,
	input wire logic i_circuit_fault,
	input wire logic i_key_press,
	output logic o_key_accept,
	output logic o_meas_start,
	output logic o_busy,
	output thh_pkg::thh_pins_t o_pins
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		thh_pkg::thh_state_t fsm;
		logic [thh_pkg::CNT_W-1:0] cnt;
		logic [thh_pkg::CNT_W-1:0] wait_len;
		logic meas_start;
		logic key_accept;
		logic lock_s1;
		logic lock_s2;
		logic pwr_s1;
		logic pwr_s2;
		logic alarm_latch;
		logic busy;
		thh_pkg::thh_pins_t pins;
	} thh_hs_state_t;

	thh_hs_state_t st_ff;
	thh_hs_state_t nxt_st;

	logic trig_level;
	logic trig_rise;
	logic trig_fall;
	logic trig_edge;
	logic [thh_pkg::CNT_W-1:0] disp_len;
	logic [thh_pkg::CNT_W-1:0] opt_len;

	// The trigger pin is asynchronous to the meter clock.
	thh_sync u_trig_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_async(i_ext_trigger_n),
		.o_level(trig_level),
		.o_rise(trig_rise),
		.o_fall(trig_fall)
	);

	assign trig_edge = i_cfg.trig_rising ? trig_rise : trig_fall;

	// Wait length: display time, base wait, option costs, and beeper time.
	// The option cost per frequency point is an estimate kept small on purpose.
	assign disp_len = thh_pkg::CNT_W'(thh_pkg::DISP_BASE_CYC)
		+ thh_pkg::CNT_W'(i_cfg.meas_points * thh_pkg::DISP_PT_CYC);
	assign opt_len = thh_pkg::CNT_W'(({1'h0, i_cfg.limit_on} + {1'h0, i_cfg.bin_on})
		* i_cfg.freq_points * thh_pkg::OPT_CYC);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		if (i_ce) begin
			// The start pulse lasts one enabled cycle; a low enable freezes it.
			nxt_st.meas_start = 1'h0;
			// Power loss passes two flops; it comes from outside this domain.
			nxt_st.pwr_s1 = i_power_loss;
			nxt_st.pwr_s2 = st_ff.pwr_s1;
			nxt_st.lock_s1 = i_key_lock_n;
			nxt_st.lock_s2 = st_ff.lock_s1;
			nxt_st.key_accept = i_key_press & st_ff.lock_s2;
			// Fault alarms latch; power alarm follows the loss only.
			nxt_st.alarm_latch = st_ff.alarm_latch | i_selftest_fault | i_circuit_fault;
			nxt_st.pins.alarm_n = ~(nxt_st.alarm_latch | st_ff.pwr_s2);
			unique case (st_ff.fsm)
				thh_pkg::THH_IDLE: begin
					if (trig_edge) begin
						// New cycle releases the handshake outputs.
						nxt_st.pins.analog_done_n = thh_pkg::OUT_IDLE_N;
						nxt_st.pins.cycle_done_n = thh_pkg::OUT_IDLE_N;
						nxt_st.cnt = '0;
						nxt_st.fsm = thh_pkg::THH_DELAY;
					end
				end
				thh_pkg::THH_DELAY: begin
					// Start well inside the allowed delay: a fixed two cycles.
					nxt_st.cnt = st_ff.cnt + 1'h1;
					if (st_ff.cnt >= thh_pkg::CNT_W'(1)) begin
						nxt_st.meas_start = 1'h1;
						nxt_st.fsm = thh_pkg::THH_ANALOG;
					end
				end
				thh_pkg::THH_ANALOG: begin
					if (i_analog_end) begin
						nxt_st.pins.analog_done_n = 1'h0;
						nxt_st.pins.no_contact_n = ~i_result.contact_fail;
						nxt_st.pins.no_bin_match_n = ~(i_cfg.bin_on & i_result.no_bin_match);
						nxt_st.pins.fail_n = ~(i_result.contact_fail
							| (i_cfg.bin_on & i_result.no_bin_match)
							| (i_cfg.limit_on & i_result.limit_fail));
						nxt_st.cnt = '0;
						nxt_st.fsm = thh_pkg::THH_COMPARE;
					end
				end
				thh_pkg::THH_COMPARE: begin
					nxt_st.cnt = st_ff.cnt + 1'h1;
					if (st_ff.cnt >= thh_pkg::CNT_W'(thh_pkg::CMP_CYC - 1)) begin
						nxt_st.pins.cycle_done_n = 1'h0;
						nxt_st.cnt = '0;
						nxt_st.wait_len = thh_pkg::CNT_W'(thh_pkg::WAIT_BASE_CYC) + disp_len
							+ opt_len
							+ (i_cfg.beeper_on ? thh_pkg::CNT_W'(thh_pkg::BEEP_CYC) : '0);
						nxt_st.fsm = thh_pkg::THH_WAIT;
					end
				end
				thh_pkg::THH_WAIT: begin
					// Triggers in this state are dropped.
					nxt_st.cnt = st_ff.cnt + 1'h1;
					if (st_ff.cnt >= st_ff.wait_len - 1'h1) begin
						nxt_st.fsm = thh_pkg::THH_IDLE;
					end
				end
			endcase
			// Busy is registered so that the output comes straight from a flop.
			nxt_st.busy = nxt_st.fsm != thh_pkg::THH_IDLE;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '{fsm: thh_pkg::THH_IDLE, cnt: '0, wait_len: '0, meas_start: 1'h0,
				key_accept: 1'h0, lock_s1: 1'h1, lock_s2: 1'h1, pwr_s1: 1'h0, pwr_s2: 1'h0,
				alarm_latch: 1'h0, busy: 1'h0, pins: '1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_pins = st_ff.pins;
	assign o_meas_start = st_ff.meas_start;
	assign o_key_accept = st_ff.key_accept;
	assign o_busy = st_ff.busy;

	// ****************************************
	// Checks
	// ****************************************
	a_start_after_trig: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && st_ff.fsm == thh_pkg::THH_IDLE && trig_edge) ##1 i_ce ##1 i_ce
		|=> o_meas_start)
		else $error("measurement did not start after trigger");
	a_analog_before_done: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_pins.cycle_done_n) |-> !o_pins.analog_done_n)
		else $error("cycle done before analog done");
	a_fail_on_contact: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_pins.no_contact_n |-> !o_pins.fail_n)
		else $error("contact fail without overall fail");
	a_release_on_trig: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && st_ff.fsm == thh_pkg::THH_IDLE && trig_edge) |=>
		o_pins.cycle_done_n && o_pins.analog_done_n)
		else $error("handshake not released on trigger");
	a_key_locked: assert property (@(posedge i_clk) disable iff (i_rst)
		(!st_ff.lock_s2 && i_ce) |=> !o_key_accept)
		else $error("key accepted while locked");
	a_alarm_power: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && st_ff.pwr_s2) |=> !o_pins.alarm_n)
		else $error("no alarm during power loss");
	a_alarm_fault: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_selftest_fault) |=> !o_pins.alarm_n [*2])
		else $error("fault alarm not held");
	a_wait_ignores: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_ff.fsm == thh_pkg::THH_WAIT) |=> !o_meas_start)
		else $error("trigger accepted during wait");
	a_done_held: assert property (@(posedge i_clk) disable iff (i_rst)
		(!o_pins.cycle_done_n && !(i_ce && st_ff.fsm == thh_pkg::THH_IDLE && trig_edge))
		|=> !o_pins.cycle_done_n)
		else $error("cycle done dropped before next trigger");
	a_alarm_follows: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && !st_ff.pwr_s2 && !st_ff.alarm_latch && !i_selftest_fault && !i_circuit_fault)
		|=> o_pins.alarm_n)
		else $error("alarm held without a cause");
	a_wait_drops_trig: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && st_ff.fsm == thh_pkg::THH_WAIT && trig_edge)
		|=> !o_pins.cycle_done_n && st_ff.fsm != thh_pkg::THH_DELAY)
		else $error("trigger taken during post-cycle wait");
	a_done_after_cmp: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_pins.cycle_done_n) |-> $past(st_ff.fsm) == thh_pkg::THH_COMPARE)
		else $error("cycle done outside compare end");
	a_contact_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && st_ff.fsm == thh_pkg::THH_ANALOG && i_analog_end && i_result.contact_fail)
		|=> !o_pins.no_contact_n)
		else $error("contact fail not flagged");

endmodule : thh_handshake

// ---- logic/thh_pkg.sv ----
// Package with constants and carrier types of the handler handshake block.
package thh_pkg;

	// ****************************************
	// Timing constants
	// ****************************************
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned START_DELAY_US = 600;
	localparam int unsigned START_DELAY_CYC = START_DELAY_US * (CLK_HZ / 1000000);
	localparam int unsigned CMP_TIME_US = 500;
	localparam int unsigned CMP_CYC = CMP_TIME_US * (CLK_HZ / 1000000);
	localparam int unsigned WAIT_BASE_MS = 5;
	localparam int unsigned WAIT_BASE_CYC = WAIT_BASE_MS * (CLK_HZ / 1000);
	localparam int unsigned BEEP_MS = 100;
	localparam int unsigned BEEP_CYC = BEEP_MS * (CLK_HZ / 1000);
	localparam int unsigned DISP_BASE_MS = 3;
	localparam int unsigned DISP_BASE_CYC = DISP_BASE_MS * (CLK_HZ / 1000);
	localparam int unsigned DISP_PT_MS = 6;
	localparam int unsigned DISP_PT_CYC = DISP_PT_MS * (CLK_HZ / 1000);
	localparam int unsigned OPT_MS = 1;
	localparam int unsigned OPT_CYC = OPT_MS * (CLK_HZ / 1000);
	// Wide enough for the longest wait that 255 points with every option can ask for.
	localparam int unsigned CNT_W = 26;
	localparam int unsigned PTS_W = 8;

	// ****************************************
	// Reset values and state types
	// ****************************************
	localparam logic OUT_IDLE_N = 1'h1;

	typedef enum {
		THH_IDLE,
		THH_DELAY,
		THH_ANALOG,
		THH_COMPARE,
		THH_WAIT
	} thh_state_t;

	// Configuration set by the instrument firmware.
	typedef struct packed {
		logic trig_rising;
		logic beeper_on;
		logic limit_on;
		logic bin_on;
		logic [PTS_W-1:0] meas_points;
		logic [PTS_W-1:0] freq_points;
	} thh_cfg_t;

	// Results delivered by the measurement engine when analog acquisition ends.
	typedef struct packed {
		logic contact_fail;
		logic no_bin_match;
		logic limit_fail;
	} thh_result_t;

	// Active-low outputs towards the handler.
	typedef struct packed {
		logic analog_done_n;
		logic cycle_done_n;
		logic no_contact_n;
		logic fail_n;
		logic no_bin_match_n;
		logic alarm_n;
	} thh_pins_t;

endpackage : thh_pkg

// ---- logic/thh_sync.sv ----
// Two-flop synchroniser with edge detection on the synchronised level.
module thh_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} thh_sync_state_t;

	thh_sync_state_t st_ff;
	thh_sync_state_t nxt_st;

	// The first stage feeds only the second one.
	always_comb begin
		nxt_st = st_ff;
		if (i_ce) begin
			nxt_st.s1 = i_async;
			nxt_st.s2 = st_ff.s1;
			nxt_st.s3 = st_ff.s2;
		end
	end

	// Idle high, since the pins are active low.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= 3'h7;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_level = st_ff.s2;
	assign o_rise = st_ff.s2 & ~st_ff.s3;
	assign o_fall = ~st_ff.s2 & st_ff.s3;

endmodule : thh_sync

// ---- verif/tb.sv ----
// Self-checking testbench of the handler handshake block.
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch at %0t: %s", $time, m); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'h0;
	logic i_rst = 1'h1;
	logic lock_n = 1'h1;
	logic a_end = 1'h0;
	logic fire = 1'h0;
	logic st = 1'h0;
	logic pl = 1'h0;
	logic cf = 1'h0;
	logic kp = 1'h0;
	logic key_acc, mstart, busy, trig_n, seen_fail_n;
	thh_pkg::thh_cfg_t cfg = '0;
	thh_pkg::thh_result_t res = '0;
	thh_pkg::thh_pins_t pins;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_start = 0;

	// ****************************************
	// Instances, clock and monitors
	// ****************************************
	thh_handshake thh_handshake_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1),
		.i_ext_trigger_n(trig_n), .i_key_lock_n(lock_n), .i_cfg(cfg),
		.i_analog_end(a_end), .i_result(res), .i_selftest_fault(st),
		.i_power_loss(pl), .i_circuit_fault(cf), .i_key_press(kp),
		.o_key_accept(key_acc), .o_meas_start(mstart), .o_busy(busy), .o_pins(pins));
	thh_handler_model thh_handler_model_inst (.i_clk(i_clk), .i_fire(fire),
		.i_rising(cfg.trig_rising), .i_pins(pins), .o_ext_trigger_n(trig_n),
		.o_fail_n(seen_fail_n));

	// Clock of 40 ns period.
	always #20 i_clk = ~i_clk;

	// Counting start pulses catches both missing and spurious measurements.
	always @(posedge i_clk) begin
		if (mstart === 1'h1) n_start++;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	task automatic do_reset();
		i_rst = 1'h1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'h0;
		repeat (5) @(negedge i_clk);
		`CHK(pins, 6'h3F, "idle pins")
	endtask : do_reset

	// One measurement cycle, then a trigger inside the post-cycle wait.
	task automatic meas(input logic [3:0] c, input thh_pkg::thh_result_t r);
		int n;
		thh_pkg::thh_pins_t p;
		int unsigned w;
		cfg = {c, 8'h01, 8'h01};
		do_reset();
		n = n_start;
		// Non-blocking, since the handler model samples fire on this same edge.
		fire <= 1'h1;
		@(negedge i_clk);
		fire <= 1'h0;
		for (int k = 0; k < 15000 && n_start == n; k++) @(negedge i_clk);
		`CHK(n_start, n + 1, "start delay")
		`CHK(busy, 1'h1, "busy in cycle")
		res = r;
		a_end = 1'h1;
		for (n = 0; n < 10 && pins.analog_done_n; n++) @(negedge i_clk);
		a_end = 1'h0;
		`CHK(pins[5:4], 2'h1, "analog end before cycle end")
		for (n = 0; n < 13000 && pins.cycle_done_n; n++) @(negedge i_clk);
		`CHK(n inside {[12499:12501]}, 1'h1, "compare time")
		p = '1;
		p.analog_done_n = 1'h0;
		p.cycle_done_n = 1'h0;
		p.no_contact_n = ~r.contact_fail;
		p.no_bin_match_n = ~(c[0] & r.no_bin_match);
		p.fail_n = ~(r.contact_fail | (c[0] & r.no_bin_match) | (c[1] & r.limit_fail));
		`CHK(pins, p, "results at cycle end")
		// One measurement and one frequency point; the full wait is too long to run.
		w = thh_pkg::WAIT_BASE_CYC + thh_pkg::DISP_BASE_CYC + thh_pkg::DISP_PT_CYC
			+ (int'(c[1]) + int'(c[0])) * thh_pkg::OPT_CYC + (c[2] ? thh_pkg::BEEP_CYC : 0);
		`CHK(thh_handshake_inst.st_ff.wait_len, w, "post-cycle wait")
		@(negedge i_clk);
		`CHK(seen_fail_n, p.fail_n, "handler read")
		n = n_start;
		fire <= 1'h1;
		@(negedge i_clk);
		fire <= 1'h0;
		repeat (400) @(negedge i_clk);
		`CHK(n_start, n, "early trigger ignored")
		`CHK(busy, 1'h1, "busy in wait")
		`CHK(pins, p, "pins hold")
	endtask : meas

	// ****************************************
	// Test sequence
	// ****************************************
	// Key gating, then alarms, then a no-fail beeper cycle and one cycle per fail cause, across both edge modes.
	initial begin
		do_reset();
		for (int i = 0; i < 2; i++) begin
			lock_n = i[0];
			repeat (4) @(negedge i_clk);
			kp = 1'h1;
			@(negedge i_clk);
			kp = 1'h0;
			`CHK(key_acc, i[0], "key gate")
		end
		pl = 1'h1;
		repeat (5) @(negedge i_clk);
		`CHK(pins.alarm_n, 1'h0, "power alarm")
		pl = 1'h0;
		repeat (5) @(negedge i_clk);
		`CHK(pins.alarm_n, 1'h1, "power alarm release")
		for (int i = 0; i < 2; i++) begin
			{st, cf} = 2'h1 << i;
			@(negedge i_clk);
			{st, cf} = 2'h0;
			repeat (8) @(negedge i_clk);
			`CHK(pins.alarm_n, 1'h0, "latched alarm")
			do_reset();
		end
		meas(4'h4, 3'h2);
		meas(4'h8, 3'h4);
		meas(4'h1, 3'h2);
		meas(4'hA, 3'h1);
		test_done();
	end

	// Watchdog well beyond the expected run of about 52000 cycles.
	initial begin
		#(80000 * 40);
		n_mismatch++;
		test_done();
	end
endmodule : tb

// ---- verif/thh_handler_model.sv ----
// Handler model that pulses the trigger pin and reads results at cycle end.
module thh_handler_model (
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic i_rising,
	input wire thh_pkg::thh_pins_t i_pins,
	output logic o_ext_trigger_n,
	output logic o_fail_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Trigger and result reading
	// ****************************************
	// The pulse is held just over one microsecond, the shortest the pin accepts.
	localparam int PULSE_CYC = 25;
	int cnt = 0;
	initial o_ext_trigger_n = 1'h1;
	initial o_fail_n = 1'h1;

	// The idle level follows the edge setting, so only the chosen edge is active.
	always @(negedge i_clk) begin
		if (cnt > 0) cnt <= cnt - 1;
		else if (i_fire) cnt <= PULSE_CYC;
		o_ext_trigger_n <= ((cnt > 0 || i_fire) ~^ i_rising);
	end

	// Data is only trusted once the cycle end is signalled.
	always @(negedge i_clk) begin
		if (!i_pins.cycle_done_n) o_fail_n <= i_pins.fail_n;
	end
endmodule : thh_handler_model
